// >>> core/cwd_defs.svh
`ifndef CWD_DEFS_SVH
`define CWD_DEFS_SVH

// register address and power-on value
`define CWD_CTRL_ADDR 8'hC0
`define CWD_CTRL_RESET 8'h10

// field positions in wdog_control_reg
`define CWD_SCALE_HI 7
`define CWD_SCALE_LO 4
`define CWD_IRQ_BIT 3
`define CWD_FLAG_BIT 2
`define CWD_EN_BIT 1
`define CWD_UNLOCK_BIT 0

// timing: base period in crystal cycles, and the immediate-reset code
`define CWD_BASE_PERIOD 17'h00200
`define CWD_SCALE_RESET 4'h1
`define CWD_SCALE_IMMEDIATE 4'h8
`define CWD_COUNT_ALL_ONES 16'hFFFF
`define CWD_COUNT_ZERO 16'h0000
`define CWD_COUNT_ONE 16'h0001

`endif

// >>> core/cwd_pkg.sv
package cwd_pkg;

   typedef enum logic [1:0] {
      CWD_ULK_IDLE,
      CWD_ULK_ARMING,
      CWD_ULK_OPEN
   } cwd_unlock_type;

   typedef struct packed {
      logic [2:0] xs;
      logic [3:0] scale;
      logic irq_mode;
      logic flag;
      logic en;
      cwd_unlock_type ulk;
      logic clear;
      logic [7:0] rdata;
      logic wreset;
      logic wirq;
   } cwd_state_type;

   typedef struct packed {
      logic [15:0] count;
      logic expired;
   } cwd_cnt_state_type;

endpackage : cwd_pkg

// >>> core/cwd_cnt_if.sv
`timescale 1ns/1ps
interface cwd_cnt_if;
   logic tick;
   logic clear;
   logic [15:0] last;
   logic expired;
   logic [15:0] count;

   modport ctl (output tick, output clear, output last,
                input expired, input count);
   modport cnt (input tick, input clear, input last,
                output expired, output count);
endinterface : cwd_cnt_if

// >>> core/cwd_counter.sv
`timescale 1ns/1ps
`include "cwd_defs.svh"
module cwd_counter #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // control from the watchdog
   cwd_cnt_if.cnt cnt
);
   import cwd_pkg::*;

   // the interface carries sixteen-bit counts only
   if (WIDTH != 16) begin : g_width_check
      $error("cwd_counter: WIDTH must be 16");
   end

   cwd_cnt_state_type q, n;

   always_comb begin
      n = q;
      n.expired = 1'b0;
      if (cnt.clear) begin
         n.count = `CWD_COUNT_ZERO;
      end else if (cnt.tick) begin
         if (q.count == cnt.last) begin
            n.expired = 1'b1;
            n.count = `CWD_COUNT_ZERO;
         end else begin
            n.count = q.count + `CWD_COUNT_ONE;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign cnt.count = q.count;
   assign cnt.expired = q.expired;

   ////////////////////////////////////////////////////////////////////////
   tick_only_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (q.count != $past(q.count)) && !$past(cnt.clear) |-> $past(cnt.tick))
      else $error("count moved without a crystal tick");
   period_end_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      $rose(q.expired) |-> $past(q.count) == $past(cnt.last))
      else $error("expiry not at the selected terminal count");

endmodule : cwd_counter

// >>> core/cwd_watchdog.sv
`timescale 1ns/1ps
`include "cwd_defs.svh"
// What this block does
// - cleared enable stops every timeout action
// - missed re-enable raises reset or interrupt, sets flag
// - sixteen-bit counter advances on crystal clock ticks
// - scale field sits in bits seven to four
// - timeout is two-to-scale times 512 crystal periods for scale codes 0 to 7
// - writes ignored unless unlock sequence precedes them
// - resets to 10H; bit set/clear supported
// - bit three routes expiry to high-priority interrupt
// - flag set on expiry, survives watchdog reset
// - enable restarts counter; cleared by listed events
// - write accepted only in instruction after unlock
module cwd_watchdog (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // crystal pin, asynchronous to core_clk
   input wire logic xtal_in,
   // special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_idx,
   input wire logic sfr_bit_val,
   input wire logic sfr_instr_end,
   output logic [7:0] sfr_rdata_q,
   // system events
   input wire logic supply_monitor_irq,
   output logic wdt_reset_q,
   output logic wdt_irq_q
);
   import cwd_pkg::*;

   cwd_state_type q, n;
   cwd_cnt_if cnt_bus ();

   cwd_counter #(
      .WIDTH(16)
   ) u_counter (
      .core_clk(core_clk),
      .rstn(rstn),
      .cnt(cnt_bus)
   );

   ////////////////////////////////////////////////////////////////////////
   logic hit;
   logic any_wr;
   logic [7:0] cur;
   logic [7:0] newval;
   logic accept;
   logic arm;
   logic fire;
   logic [16:0] span;

   always_comb begin
      hit = (sfr_addr == `CWD_CTRL_ADDR);
      any_wr = hit && (sfr_wr || sfr_bit_wr);
      cur = {q.scale, q.irq_mode, q.flag, q.en, (q.ulk != CWD_ULK_IDLE)};
      newval = cur;
      if (sfr_wr) begin
         newval = sfr_wdata;
      end else if (sfr_bit_wr) begin
         newval[sfr_bit_idx] = sfr_bit_val;
      end
      accept = any_wr && (q.ulk == CWD_ULK_OPEN);
      // arm on bit 0 as written, never on its read-back of 1
      arm = hit && ((sfr_wr && sfr_wdata[`CWD_UNLOCK_BIT]) ||
            (sfr_bit_wr && sfr_bit_idx == 3'(`CWD_UNLOCK_BIT) &&
            sfr_bit_val));
      // reserved codes above the immediate one never time out
      fire = q.en && ((!q.scale[3] && cnt_bus.expired) ||
             (q.scale == `CWD_SCALE_IMMEDIATE));
      span = (`CWD_BASE_PERIOD << q.scale[2:0]) - 17'h00001;
   end

   always_comb begin
      n = q;
      n.xs = {q.xs[1:0], xtal_in};
      n.wreset = 1'b0;
      n.wirq = 1'b0;
      n.clear = 1'b0;
      // unlock window tracks instruction boundaries, not core cycles
      if (arm) begin
         n.ulk = CWD_ULK_ARMING;
      end else if (accept) begin
         n.ulk = CWD_ULK_IDLE;
      end else if (sfr_instr_end) begin
         unique case (q.ulk)
            CWD_ULK_ARMING: n.ulk = CWD_ULK_OPEN;
            CWD_ULK_OPEN: n.ulk = CWD_ULK_IDLE;
            CWD_ULK_IDLE: n.ulk = CWD_ULK_IDLE;
         endcase
      end
      if (accept) begin
         n.scale = newval[`CWD_SCALE_HI:`CWD_SCALE_LO];
         n.irq_mode = newval[`CWD_IRQ_BIT];
         n.flag = q.flag && newval[`CWD_FLAG_BIT];
         n.en = newval[`CWD_EN_BIT];
         n.clear = newval[`CWD_EN_BIT];
      end
      if (supply_monitor_irq) begin
         n.en = 1'b0;
      end
      if (fire) begin
         n.flag = 1'b1;
         n.clear = 1'b1;
         if (q.irq_mode && !q.scale[3]) begin
            n.wirq = 1'b1;
         end else begin
            n.wreset = 1'b1;
            n.en = 1'b0;
         end
      end
      if (!n.en) begin
         n.clear = 1'b1;
      end
      n.rdata = hit ? cur : 8'h00;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.scale <= `CWD_SCALE_RESET;
      end else begin
         q <= n;
      end
   end

   // first sync stage feeds only the second; edge taken on stages 2 and 3
   assign cnt_bus.tick = q.xs[1] && !q.xs[2];
   assign cnt_bus.clear = q.clear;
   assign cnt_bus.last = q.scale[3] ? `CWD_COUNT_ALL_ONES : span[15:0];
   assign sfr_rdata_q = q.rdata;
   assign wdt_reset_q = q.wreset;
   // dedicated line so the core can bypass its global interrupt mask
   assign wdt_irq_q = q.wirq;

   ////////////////////////////////////////////////////////////////////////
   no_fire_off_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      (wdt_reset_q || wdt_irq_q) |-> $past(q.en))
      else $error("timeout action while disabled");
   expiry_flag_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.en && cnt_bus.expired && !q.scale[3] |=> q.flag && (wdt_reset_q ||
      wdt_irq_q))
      else $error("expiry did not act and set flag");
   scale_read_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      hit |=> sfr_rdata_q[7:4] == $past(q.scale))
      else $error("scale not read back in bits 7:4");
   locked_write_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      hit && sfr_wr && q.ulk != CWD_ULK_OPEN |=> $stable(q.scale) &&
      $stable(q.irq_mode))
      else $error("locked write changed the register");
   reset_value_a: assert property (
      @(posedge core_clk)
      $rose(rstn) |-> {q.scale, q.irq_mode, q.flag, q.en} == 7'h08)
      else $error("power-on value wrong");
   irq_route_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.en && q.irq_mode && cnt_bus.expired && !q.scale[3] |=>
      wdt_irq_q && !wdt_reset_q)
      else $error("interrupt mode gave a reset");
   flag_kept_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wdt_reset_q |-> q.flag && !q.en ##1 q.flag)
      else $error("watchdog reset lost flag or kept enable");
   unlock_close_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.ulk == CWD_ULK_OPEN && sfr_instr_end && !any_wr |=>
      q.ulk == CWD_ULK_IDLE)
      else $error("unlock window outlived one instruction");
   immediate_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.en && q.scale == `CWD_SCALE_IMMEDIATE |=> wdt_reset_q)
      else $error("code 8 did not reset at once");
   flag_clear_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      accept && !newval[`CWD_FLAG_BIT] && !fire |=> !q.flag)
      else $error("software clear of the flag ignored");
   flag_hold_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.flag && !(accept && !newval[`CWD_FLAG_BIT]) |=> q.flag)
      else $error("flag dropped without a software clear");
   flag_set_only_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !q.flag && !fire |=> !q.flag)
      else $error("flag set without an expiry");
   kick_clear_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      accept && newval[`CWD_EN_BIT] |=> cnt_bus.clear)
      else $error("enable write did not restart the counter");
   supply_off_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      supply_monitor_irq |=> !q.en)
      else $error("supply event left the watchdog enabled");
   wdog_off_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      !q.en |=> cnt_bus.clear)
      else $error("counter ran while disabled");
   reserved_quiet_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.scale > `CWD_SCALE_IMMEDIATE |=> !wdt_reset_q && !wdt_irq_q)
      else $error("reserved code timed out");
   arm_track_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      arm |=> q.ulk == CWD_ULK_ARMING)
      else $error("unlock write did not arm");
   window_open_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      q.ulk == CWD_ULK_ARMING && sfr_instr_end && !any_wr |=>
      q.ulk == CWD_ULK_OPEN)
      else $error("window did not open after the unlock");
   accept_write_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      hit && sfr_wr && q.ulk == CWD_ULK_OPEN |=>
      q.scale == $past(sfr_wdata[`CWD_SCALE_HI:`CWD_SCALE_LO]))
      else $error("unlocked write did not land");
   irq_flag_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wdt_irq_q |-> q.flag)
      else $error("interrupt without the flag");
   tick_edge_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      cnt_bus.tick |=> !cnt_bus.tick)
      else $error("crystal tick longer than one cycle");
   reset_single_a: assert property (
      @(posedge core_clk) disable iff (!rstn)
      wdt_reset_q |=> !wdt_reset_q)
      else $error("reset request longer than one cycle");

endmodule : cwd_watchdog

// >>> tb/cwd_watchdog_test.sv
`timescale 1ns/1ps
module cwd_watchdog_test;
   logic core_clk = 1'h0;
   logic rstn = 1'h0;
   logic xtal_in = 1'h0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata_q;
   logic sfr_wr = 1'h0;
   logic sfr_bit_wr = 1'h0;
   logic sfr_bit_val = 1'h0;
   logic [2:0] sfr_bit_idx = 3'h0;
   logic sfr_instr_end = 1'h0;
   logic supply_monitor_irq = 1'h0;
   logic wdt_reset_q;
   logic wdt_irq_q;
   logic [15:0] seed = 16'hD4A1;
   int errors = 0;
   int tests_run = 0;
   int ticks = 0;
   int t0;
   int hit;
   int el;

   cwd_watchdog dut (.core_clk(core_clk), .rstn(rstn), .xtal_in(xtal_in),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx),
      .sfr_bit_val(sfr_bit_val), .sfr_instr_end(sfr_instr_end),
      .sfr_rdata_q(sfr_rdata_q), .supply_monitor_irq(supply_monitor_irq),
      .wdt_reset_q(wdt_reset_q), .wdt_irq_q(wdt_irq_q));

   ////////////////////////////////////////////////////////////////////////
   always #50 core_clk = ~core_clk;
   // crystal sped up to keep the run short; expectations count its ticks
   // its edges fall on falling core edges, clear of the sampling edge
   always #400 xtal_in = ~xtal_in;
   always @(posedge xtal_in) ticks++;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   function automatic int tmo(input int s);
      return 512 << s;
   endfunction : tmo

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [7:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic rd(input string what, input logic [7:0] exp);
      @(posedge core_clk);
      sfr_addr <= 8'hC0;
      @(posedge core_clk);
      @(negedge core_clk);
      chk(what, exp, sfr_rdata_q);
   endtask : rd

   // single-bit write, then the end of its instruction
   task automatic bw(input logic [2:0] idx, input logic val);
      @(posedge core_clk);
      sfr_addr <= 8'hC0;
      sfr_bit_idx <= idx;
      sfr_bit_val <= val;
      sfr_bit_wr <= 1'h1;
      @(posedge core_clk);
      sfr_bit_wr <= 1'h0;
      sfr_instr_end <= 1'h1;
      @(posedge core_clk);
      sfr_instr_end <= 1'h0;
   endtask : bw

   // optional unlock by bit set, then the byte write
   task automatic wr(input logic [7:0] d, input bit unl);
      if (unl) begin
         bw(3'h0, 1'h1);
      end
      @(posedge core_clk);
      sfr_addr <= 8'hC0;
      sfr_wr <= 1'h1;
      sfr_wdata <= d;
      @(posedge core_clk);
      sfr_wr <= 1'h0;
      t0 = ticks;
   endtask : wr

   // 1 = reset pulse, 2 = interrupt pulse; a missed one ends the run
   task automatic wt(input int n, input int want, output int got);
      got = 0;
      for (int i = 0; i < n && got == 0; i++) begin
         @(negedge core_clk);
         if (wdt_reset_q === 1'h1) got = 1;
         if (wdt_irq_q === 1'h1) got = 2;
      end
      chk("event kind", 8'(want), 8'(got));
      if (want != 0 && got == 0) give_verdict();
   endtask : wt

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge core_clk);
      rstn <= 1'h1;
      rd("reset value", 8'h10);
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         wr(seed[7:0] & 8'hFE, 1'b0);
         rd("locked write", 8'h10);
      end
      for (int s = 0; s < 2; s++) begin
         wr({s[3:0], 4'h2}, 1'b1);
         wt(tmo(s) * 10 + 100, 1, hit);
         el = ticks - t0;
         chk("ticks", 8'h01, 8'(el >= tmo(s) - 1 && el <= tmo(s) + 2));
         rd("after reset", {s[3:0], 4'h4});
      end
      wr(8'h0A, 1'b1);
      wt(tmo(0) * 10 + 100, 2, hit);
      rd("after interrupt", 8'h0E);
      @(posedge core_clk);
      supply_monitor_irq <= 1'h1;
      @(posedge core_clk);
      supply_monitor_irq <= 1'h0;
      rd("supply event", 8'h0C);
      wr(8'h02, 1'b1);
      wr(8'h00, 1'b1);
      rd("disabled", 8'h00);
      wt(tmo(0) * 12, 0, hit);
      // enable by bit set; the locked byte write after it must not land
      bw(3'h0, 1'h1);
      bw(3'h1, 1'h1);
      wr(8'h00, 1'b0);
      rd("bit set", 8'h02);
      // kick before the period ends, then let it run out
      wt(3000, 0, hit);
      wr(8'h02, 1'b1);
      wt(3000, 0, hit);
      wt(tmo(0) * 10 + 100, 1, hit);
      wr(8'h82, 1'b1);
      wt(8, 1, hit);
      wr(8'h8A, 1'b1);
      wt(8, 1, hit);
      wr(8'h92, 1'b1);
      wt(tmo(1) * 10, 0, hit);
      rd("reserved code", 8'h92);
      give_verdict();
   end
endmodule : cwd_watchdog_test
